// ### verilog/mrsf_pkg.sv
// Constants and types shared by the RTU slave framer
package mrsf_pkg;

	// Clock and sampling tick
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Baud selection
	typedef enum logic [1:0] {
		MRSF_BAUD_4800 = 2'h0,
		MRSF_BAUD_9600 = 2'h1,
		MRSF_BAUD_19200 = 2'h2,
		MRSF_BAUD_HIGH = 2'h3
	} mrsf_baud_e;

	// Idle limits in 1 ms ticks: end of frame, and mid-frame fault
	localparam logic [3:0] END_MS_4800 = 4'h8;
	localparam logic [3:0] FAULT_MS_4800 = 4'h4;
	localparam logic [3:0] END_MS_9600 = 4'h4;
	localparam logic [3:0] FAULT_MS_9600 = 4'h2;
	localparam logic [3:0] END_MS_19200 = 4'h2;
	localparam logic [3:0] FAULT_MS_19200 = 4'h1;
	localparam logic [3:0] END_MS_HIGH = 4'h1;
	localparam logic [3:0] FAULT_MS_HIGH = 4'h1;
	localparam logic [3:0] IDLE_MS_MAX = 4'hF;

	// Least response delay: 3.5 characters of 10 bits, rounded up (the end-of-frame limit at the high rate), plus turnaround
	localparam int GAP_TENTH_CHARS = 35;
	localparam int CHAR_BITS = 10;
	localparam int TURNAROUND_WAIT_MS = 1;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam logic [15:0] MIN_DLY_4800 =
		16'((GAP_TENTH_CHARS * CHAR_BITS * 1000 + 10 * BAUD_4800 - 1) / (10 * BAUD_4800) + TURNAROUND_WAIT_MS);
	localparam logic [15:0] MIN_DLY_9600 =
		16'((GAP_TENTH_CHARS * CHAR_BITS * 1000 + 10 * BAUD_9600 - 1) / (10 * BAUD_9600) + TURNAROUND_WAIT_MS);
	localparam logic [15:0] MIN_DLY_19200 =
		16'((GAP_TENTH_CHARS * CHAR_BITS * 1000 + 10 * BAUD_19200 - 1) / (10 * BAUD_19200) + TURNAROUND_WAIT_MS);
	localparam logic [15:0] MIN_DLY_HIGH = 16'(int'(END_MS_HIGH) + TURNAROUND_WAIT_MS);

	// Frame layout
	localparam logic [8:0] MIN_LEGAL_LEN = 9'h003;
	localparam logic [8:0] MIN_CRC_LEN = 9'h004;
	localparam logic [8:0] MAX_FRAME_LEN = 9'h100;
	localparam logic [8:0] HDR_LEN = 9'h002;
	localparam logic [8:0] EXC_BODY_LEN = 9'h003;
	localparam logic [7:0] BROADCAST_ADDR = 8'h00;
	localparam int BUF_DEPTH = 256;

	// Check sequence
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// Exception answer
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_BAD_FRAME = 8'h03;
	localparam logic [7:0] EXC_SLAVE_FAULT = 8'h04;
	localparam logic [7:0] EXC_OVER_RANGE = 8'h05;
	localparam logic [7:0] EXC_READ_ONLY = 8'h06;
	localparam logic [7:0] EXC_RUN_LOCKED = 8'h07;
	localparam logic [7:0] EXC_PASSWORD = 8'h08;

	// Sequencer states, gray along receive, execute, wait, send, drain
	typedef enum logic [2:0] {
		S_RX = 3'h0,
		S_APP = 3'h1,
		S_DLY = 3'h3,
		S_SEND = 3'h2,
		S_DRAIN = 3'h6
	} mrsf_state_e;

endpackage

// ### verilog/mrsf_top.sv
// RTU slave framer: idle-gap delimiting, frame checks, reply or exception, response delay
`timescale 1ns/1ps
`default_nettype none
module mrsf_top
	import mrsf_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] baud_sel,
	input wire logic [7:0] station_addr,
	input wire logic [15:0] response_delay_setting,
	input wire logic [15:0] comm_timeout_setting,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_err,
	output logic rx_discard,
	output logic req_valid,
	output logic [7:0] req_func,
	output logic [8:0] req_len,
	output logic req_broadcast,
	input wire logic [7:0] req_rd_addr,
	output logic [7:0] req_rd_data,
	input wire logic app_done,
	input wire logic [7:0] app_exc,
	input wire logic [7:0] app_resp_len,
	input wire logic resp_we,
	input wire logic [7:0] resp_waddr,
	input wire logic [7:0] resp_wdata,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic tx_empty,
	output logic driver_en,
	output logic comm_timeout
);

	function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] data);
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction

	function automatic logic [3:0] end_ms(input logic [1:0] sel);
		case (mrsf_baud_e'(sel))
			MRSF_BAUD_4800: end_ms = END_MS_4800;
			MRSF_BAUD_9600: end_ms = END_MS_9600;
			MRSF_BAUD_19200: end_ms = END_MS_19200;
			default: end_ms = END_MS_HIGH;
		endcase
	endfunction

	function automatic logic [3:0] fault_ms(input logic [1:0] sel);
		case (mrsf_baud_e'(sel))
			MRSF_BAUD_4800: fault_ms = FAULT_MS_4800;
			MRSF_BAUD_9600: fault_ms = FAULT_MS_9600;
			MRSF_BAUD_19200: fault_ms = FAULT_MS_19200;
			default: fault_ms = FAULT_MS_HIGH;
		endcase
	endfunction

	function automatic logic [15:0] min_dly(input logic [1:0] sel);
		case (mrsf_baud_e'(sel))
			MRSF_BAUD_4800: min_dly = MIN_DLY_4800;
			MRSF_BAUD_9600: min_dly = MIN_DLY_9600;
			MRSF_BAUD_19200: min_dly = MIN_DLY_19200;
			default: min_dly = MIN_DLY_HIGH;
		endcase
	endfunction

	mrsf_state_e state_r;
	logic [15:0] tick_cnt_r;
	logic tick;
	logic [3:0] idle_ms_r;
	logic in_frame_r;
	logic [8:0] rx_len_r;
	logic [15:0] rx_crc_r;
	logic rx_fault_r;
	logic [7:0] rx_addr_r;
	logic [7:0] rx_func_r;
	logic [7:0] rx_mem [BUF_DEPTH];
	logic [7:0] tx_mem [BUF_DEPTH];
	logic rx_take;
	logic frame_end;
	logic legal;
	logic crc_ok;
	logic is_bcast;
	logic [15:0] dly_ms_r;
	logic [15:0] dly_need;
	logic dly_done;
	logic [15:0] to_ms_r;
	logic [7:0] exc_r;
	logic [8:0] resp_len_r;
	logic [8:0] body_len;
	logic [8:0] tx_idx_r;
	logic [15:0] tx_crc_r;
	logic [7:0] tx_byte;
	logic tx_valid_r;
	logic [7:0] tx_data_r;
	logic last_acc;
	logic drain_armed_r;
	logic driver_en_r;
	logic req_valid_r;
	logic [8:0] req_len_r;
	logic req_bcast_r;
	logic [7:0] req_rd_data_r;
	logic rx_discard_r;
	logic comm_timeout_r;

	// 1 ms sampling tick
	assign tick = (tick_cnt_r == 16'(TICK_CYCLES_P - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= 16'h0000;
		end else if (tick) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// Bytes are taken only while listening; during a reply the line carries our own echo
	assign frame_end = in_frame_r && (idle_ms_r >= end_ms(baud_sel));
	assign rx_take = rx_valid && (state_r == S_RX) && !frame_end;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_ms_r <= 4'h0;
		end else if (rx_take) begin
			idle_ms_r <= 4'h0;
		end else if (tick && idle_ms_r != IDLE_MS_MAX) begin
			idle_ms_r <= idle_ms_r + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_frame_r <= 1'b0;
			rx_len_r <= 9'h000;
			rx_crc_r <= CRC_PRESET;
			rx_fault_r <= 1'b0;
			rx_addr_r <= 8'h00;
			rx_func_r <= 8'h00;
		end else if (frame_end) begin
			in_frame_r <= 1'b0;
		end else if (rx_take) begin
			in_frame_r <= 1'b1;
			if (!in_frame_r) begin
				rx_len_r <= 9'h001;
				rx_crc_r <= crc_byte(CRC_PRESET, rx_data);
				rx_fault_r <= rx_err;
				rx_addr_r <= rx_data;
			end else begin
				if (rx_len_r != MAX_FRAME_LEN) begin
					rx_len_r <= rx_len_r + 9'h001;
				end
				if (rx_len_r == 9'h001) begin
					rx_func_r <= rx_data;
				end
				rx_crc_r <= crc_byte(rx_crc_r, rx_data);
				// Gap at or above the fault limit, a line error or an overlong frame spoils it
				rx_fault_r <= rx_fault_r || rx_err || (idle_ms_r >= fault_ms(baud_sel))
					|| (rx_len_r == MAX_FRAME_LEN);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rx_take && (!in_frame_r || rx_len_r < MAX_FRAME_LEN)) begin
			rx_mem[in_frame_r ? rx_len_r[7:0] : 8'h00] <= rx_data;
		end
		if (resp_we) begin
			tx_mem[resp_waddr] <= resp_wdata;
		end
	end

	// Running CRC over the whole frame, check bytes included, leaves zero when intact
	assign is_bcast = (rx_addr_r == BROADCAST_ADDR);
	assign legal = !rx_fault_r && (rx_len_r >= MIN_LEGAL_LEN)
		&& (rx_addr_r == station_addr || is_bcast);
	assign crc_ok = (rx_crc_r == CRC_RESIDUE) && (rx_len_r >= MIN_CRC_LEN);

	// Delay measured from frame end; strict compare guarantees whole milliseconds
	assign dly_need = (response_delay_setting > min_dly(baud_sel)) ? response_delay_setting : min_dly(baud_sel);
	assign dly_done = (dly_ms_r > dly_need);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dly_ms_r <= 16'h0000;
		end else if (frame_end) begin
			dly_ms_r <= 16'h0000;
		end else if (tick && dly_ms_r != 16'hFFFF) begin
			dly_ms_r <= dly_ms_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_ms_r <= 16'h0000;
			comm_timeout_r <= 1'b0;
		end else if (frame_end && legal && crc_ok) begin
			to_ms_r <= 16'h0000;
			comm_timeout_r <= 1'b0;
		end else begin
			if (tick && to_ms_r != 16'hFFFF) begin
				to_ms_r <= to_ms_r + 16'h0001;
			end
			if (comm_timeout_setting != 16'h0000 && to_ms_r > comm_timeout_setting) begin
				comm_timeout_r <= 1'b1;
			end
		end
	end

	// Sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= S_RX;
			exc_r <= EXC_NONE;
			resp_len_r <= 9'h000;
		end else begin
			case (state_r)
				S_RX: begin
					if (frame_end && legal) begin
						if (!crc_ok) begin
							exc_r <= EXC_BAD_FRAME;
							state_r <= is_bcast ? S_RX : S_DLY;
						end else if (rx_func_r[7]) begin
							exc_r <= EXC_ILLEGAL_FUNC;
							state_r <= is_bcast ? S_RX : S_DLY;
						end else begin
							state_r <= S_APP;
						end
					end
				end
				S_APP: begin
					if (app_done) begin
						// Codes 02H and 04H..08H come from the executing logic unchanged
						exc_r <= app_exc;
						resp_len_r <= {1'b0, app_resp_len};
						state_r <= req_bcast_r ? S_RX : S_DLY;
					end
				end
				S_DLY: begin
					if (dly_done) begin
						state_r <= S_SEND;
					end
				end
				S_SEND: begin
					if (last_acc) begin
						state_r <= S_DRAIN;
					end
				end
				S_DRAIN: begin
					if (drain_armed_r && tx_empty) begin
						state_r <= S_RX;
					end
				end
				default: begin
					state_r <= S_RX;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_discard_r <= 1'b0;
		end else begin
			rx_discard_r <= (state_r == S_RX) && frame_end && !legal;
		end
	end

	// Request hand-off to the executing logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_valid_r <= 1'b0;
			req_len_r <= 9'h000;
			req_bcast_r <= 1'b0;
		end else begin
			req_valid_r <= (state_r == S_RX) && frame_end && legal && crc_ok && !rx_func_r[7];
			if (state_r == S_RX && frame_end) begin
				req_len_r <= rx_len_r;
				req_bcast_r <= is_bcast;
			end
		end
	end

	always_ff @(posedge clk) begin
		req_rd_data_r <= rx_mem[req_rd_addr];
	end

	// Reply bytes: address, function, body, CRC low, CRC high
	assign body_len = (exc_r != EXC_NONE) ? EXC_BODY_LEN : (HDR_LEN + resp_len_r);

	always_comb begin
		if (tx_idx_r == 9'h000) begin
			tx_byte = station_addr;
		end else if (tx_idx_r == 9'h001) begin
			tx_byte = (exc_r != EXC_NONE) ? (rx_func_r | EXC_FLAG) : rx_func_r;
		end else if (tx_idx_r < body_len) begin
			tx_byte = (exc_r != EXC_NONE) ? exc_r : tx_mem[8'(tx_idx_r - HDR_LEN)];
		end else if (tx_idx_r == body_len) begin
			tx_byte = tx_crc_r[7:0];
		end else begin
			tx_byte = tx_crc_r[15:8];
		end
	end

	assign last_acc = tx_valid_r && tx_ready && (tx_idx_r == body_len + 9'h001);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_idx_r <= 9'h000;
			tx_crc_r <= CRC_PRESET;
			tx_valid_r <= 1'b0;
			tx_data_r <= 8'h00;
		end else if (state_r != S_SEND) begin
			tx_idx_r <= 9'h000;
			tx_crc_r <= CRC_PRESET;
			tx_valid_r <= 1'b0;
		end else if (!tx_valid_r) begin
			tx_data_r <= tx_byte;
			tx_valid_r <= 1'b1;
		end else if (tx_ready) begin
			tx_valid_r <= 1'b0;
			tx_idx_r <= tx_idx_r + 9'h001;
			if (tx_idx_r < body_len) begin
				tx_crc_r <= crc_byte(tx_crc_r, tx_data_r);
			end
		end
	end

	// The transmitter may still show empty in the cycle after the last accept
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drain_armed_r <= 1'b0;
		end else begin
			drain_armed_r <= (state_r == S_DRAIN);
		end
	end

	// Driver only after the full delay, released once the last stop bit is out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			driver_en_r <= 1'b0;
		end else if (state_r == S_DLY && dly_done) begin
			driver_en_r <= 1'b1;
		end else if (state_r == S_DRAIN && drain_armed_r && tx_empty) begin
			driver_en_r <= 1'b0;
		end
	end

	assign rx_discard = rx_discard_r;
	assign req_valid = req_valid_r;
	assign req_func = rx_func_r;
	assign req_len = req_len_r;
	assign req_broadcast = req_bcast_r;
	assign req_rd_data = req_rd_data_r;
	assign tx_valid = tx_valid_r;
	assign tx_data = tx_data_r;
	assign driver_en = driver_en_r;
	assign comm_timeout = comm_timeout_r;

endmodule
`default_nettype wire

// ### sim/mrsf_monitor.sv
// Port checker for the RTU slave framer
`timescale 1ns/1ps
`default_nettype none
module mrsf_monitor #(
	parameter int TICK_CYCLES_P = 40000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] baud_sel,
	input wire logic [7:0] station_addr,
	input wire logic [15:0] comm_timeout_setting,
	input wire logic rx_valid,
	input wire logic rx_discard,
	input wire logic req_valid,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic tx_empty,
	input wire logic driver_en,
	input wire logic comm_timeout
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Cycles since the last received byte; saturates so a long idle never wraps
	int idle_cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_cnt <= 0;
		end else if (rx_valid) begin
			idle_cnt <= 0;
		end else if (idle_cnt < 65535) begin
			idle_cnt <= idle_cnt + 1;
		end
	end
	sequence s_addr_offer;
		tx_valid && tx_data == station_addr;
	endsequence
	property p_first_addr;
		$rose(driver_en) |=> s_addr_offer;
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("reply lacks own address");
	property p_disc_silent;
		rx_discard |=> !driver_en [*8];
	endproperty
	a_disc_silent: assert property (p_disc_silent) else $error("driver on after drop");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte not held");
	property p_drv_fall;
		$fell(driver_en) |-> $past(tx_empty) && !tx_valid;
	endproperty
	a_drv_fall: assert property (p_drv_fall) else $error("driver off early");
	property p_end_gap;
		(req_valid || rx_discard) && baud_sel == 2'h1 |->
			idle_cnt >= 3 * TICK_CYCLES_P && idle_cnt <= 4 * TICK_CYCLES_P + 3;
	endproperty
	a_end_gap: assert property (p_end_gap) else $error("frame end off time");
	property p_reply_gap;
		$rose(driver_en) && baud_sel == 2'h1 |-> idle_cnt >= 8 * TICK_CYCLES_P;
	endproperty
	a_reply_gap: assert property (p_reply_gap) else $error("reply too soon");
	property p_to_cause;
		$rose(comm_timeout) |-> comm_timeout_setting != 16'h0000;
	endproperty
	a_to_cause: assert property (p_to_cause) else $error("timeout while disabled");
	property p_to_clear;
		req_valid |-> ##[0:2] !comm_timeout;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("timeout not cleared");
endmodule
`default_nettype wire

// ### sim/mrsf_master.sv
// Master station model: sends request frames and takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module mrsf_master (
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic tx_empty
);
	logic [7:0] got[$];
	logic slow = 1'b0;
	int busy = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_err = 1'b0;
		tx_ready = 1'b1;
		tx_empty = 1'b1;
	end
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction
	// Between bytes the line shows the inverse, so a stale byte is never mistaken for data
	task automatic send(input logic [7:0] q[$], input int err_at, input int gap_at, input bit bad);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0] ^ {7'h00, bad});
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			if (i == gap_at) begin
				repeat (50) @(posedge clk);
			end
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data <= q[i];
			rx_err <= (i == err_at);
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_data <= ~q[i];
			rx_err <= 1'b0;
		end
	endtask
	// Slow mode stalls every other cycle; the shifter stays busy six cycles per byte
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			busy <= 6;
			tx_empty <= 1'b0;
		end else if (busy != 0) begin
			busy <= busy - 1;
		end else begin
			tx_empty <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### sim/modbus_rtu_slave_framing_test.sv
// Self-checking bench for the RTU slave framer
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framing_test;
	import mrsf_pkg::*;
	localparam int TICK_CYCLES_P = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] baud_sel = 2'h1;
	logic [15:0] response_delay_setting = 16'h0000;
	logic [15:0] comm_timeout_setting = 16'h0000;
	logic [7:0] req_rd_addr = 8'h00;
	logic app_done = 1'b0;
	logic [7:0] app_exc = 8'h00;
	logic resp_we = 1'b0;
	logic [7:0] resp_waddr = 8'h00;
	logic [7:0] resp_wdata = 8'h00;
	logic rx_valid, rx_err, rx_discard, req_valid, req_broadcast, tx_valid, tx_ready, tx_empty;
	logic driver_en, comm_timeout;
	logic [7:0] rx_data, req_func, req_rd_data, tx_data;
	logic [8:0] req_len;
	int err_count = 0;
	int n_tests = 0;
	int n_cyc = 0;
	always #12.5 clk = ~clk;
	mrsf_top #(.TICK_CYCLES_P(TICK_CYCLES_P)) uut (.clk, .rst, .baud_sel, .station_addr(8'h11),
		.response_delay_setting, .comm_timeout_setting, .rx_valid, .rx_data, .rx_err, .rx_discard,
		.req_valid, .req_func, .req_len, .req_broadcast, .req_rd_addr, .req_rd_data, .app_done, .app_exc,
		.app_resp_len(8'h02), .resp_we, .resp_waddr, .resp_wdata, .tx_valid, .tx_data, .tx_ready,
		.tx_empty, .driver_en, .comm_timeout);
	mrsf_master m (.clk, .rx_valid, .rx_data, .rx_err, .tx_valid, .tx_data, .tx_ready, .tx_empty);
	task automatic complete_run();
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		n_cyc <= n_cyc + 1;
		if (n_cyc == 30000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
		n_tests++;
		if (act !== exp) begin
			err_count++;
			$display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask
	task automatic wait_end(output int t);
		for (int i = 0; i < 300 && !(req_valid || rx_discard || driver_en); i++) begin
			@(posedge clk);
			#1;
		end
		t = n_cyc;
	endtask
	task automatic wait_drv(input logic lvl);
		for (int i = 0; i < 400 && driver_en !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	// kind: 0 dropped, 1 normal, 2 exception from executing logic, 3 exception by the block, 4 broadcast
	task automatic xact(input logic [7:0] adr, input logic [7:0] fn, input int err_at, input int gap_at,
			input bit bad, input logic [7:0] exc, input int kind);
		logic [7:0] e[$];
		logic [15:0] c;
		int t;
		int need;
		e = '{8'h11, fn | ((kind > 1) ? 8'h80 : 8'h00)};
		if (kind == 1) begin
			e.push_back(8'hA0);
			e.push_back(8'hA1);
		end else begin
			e.push_back(exc);
		end
		c = m.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		m.got.delete();
		m.send('{adr, fn, 8'h13, 8'h00}, err_at, gap_at, bad);
		wait_end(t);
		cmp(16'({req_valid, rx_discard}), 16'({kind == 1 || kind == 2 || kind == 4, kind == 0}));
		if (req_valid) begin
			cmp(16'(req_func), 16'(fn));
			cmp(16'(req_len), 16'h0006);
			cmp(16'(req_broadcast), 16'(kind == 4));
			@(posedge clk);
			req_rd_addr <= 8'h02;
			resp_we <= 1'b1;
			resp_waddr <= 8'h00;
			resp_wdata <= 8'hA0;
			@(posedge clk);
			resp_waddr <= 8'h01;
			resp_wdata <= 8'hA1;
			@(posedge clk);
			resp_we <= 1'b0;
			app_done <= 1'b1;
			app_exc <= exc;
			cmp(16'(req_rd_data), 16'h0013);
			@(posedge clk);
			app_done <= 1'b0;
		end
		wait_drv(1'b1);
		if (kind == 0 || kind == 4) begin
			cmp(16'(driver_en), 16'h0000);
		end else begin
			if (kind < 3) begin
				// Settings given by non-blocking assignment just before the call are only read here
				need = (baud_sel == 2'h0) ? int'(MIN_DLY_4800) : int'(MIN_DLY_9600);
				if (int'(response_delay_setting) > need) begin
					need = int'(response_delay_setting);
				end
				cmp(16'(n_cyc - t >= need * TICK_CYCLES_P && n_cyc - t <= need * TICK_CYCLES_P + 24), 16'h0001);
			end
			wait_drv(1'b0);
			cmp(16'(m.got.size()), 16'(e.size()));
			foreach (e[i]) begin
				cmp(16'(m.got[i]), 16'(e[i]));
			end
		end
		repeat (100) @(posedge clk);
	endtask
	task automatic t_normal();
		xact(8'h11, 8'h03, -1, -1, 1'b0, 8'h00, 1);
		response_delay_setting <= 16'h0008;
		m.slow <= 1'b1;
		xact(8'h11, 8'h06, -1, -1, 1'b0, 8'h00, 1);
		response_delay_setting <= 16'h0000;
		m.slow <= 1'b0;
	endtask
	// Slow line: longer end gap and delay, and a 2.5 ms pause mid-frame is still tolerated
	task automatic t_baud();
		baud_sel <= 2'h0;
		repeat (100) @(posedge clk);
		xact(8'h11, 8'h03, -1, -1, 1'b0, 8'h00, 1);
		xact(8'h11, 8'h03, -1, 2, 1'b0, 8'h00, 1);
		repeat (100) @(posedge clk);
		baud_sel <= 2'h1;
	endtask
	task automatic t_exc();
		for (int k = 1; k <= 8; k++) begin
			xact(8'h11, 8'h06, -1, -1, 1'b0, 8'(k), 2);
		end
		xact(8'h11, 8'h86, -1, -1, 1'b0, 8'h01, 3);
		xact(8'h11, 8'h03, -1, -1, 1'b1, 8'h03, 3);
	endtask
	task automatic t_silent();
		xact(8'h11, 8'h03, 2, -1, 1'b0, 8'h00, 0);
		xact(8'h22, 8'h03, -1, -1, 1'b0, 8'h00, 0);
		xact(8'h11, 8'h03, -1, 2, 1'b0, 8'h00, 0);
		xact(8'h00, 8'h06, -1, -1, 1'b0, 8'h00, 4);
	endtask
	task automatic t_timeout();
		cmp(16'(comm_timeout), 16'h0000);
		comm_timeout_setting <= 16'h0003;
		repeat (100) @(posedge clk);
		cmp(16'(comm_timeout), 16'h0001);
		comm_timeout_setting <= 16'h0028;
		xact(8'h11, 8'h03, -1, -1, 1'b0, 8'h00, 1);
		cmp(16'(comm_timeout), 16'h0000);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_normal();
		t_baud();
		t_exc();
		t_silent();
		t_timeout();
		complete_run();
	end
endmodule
bind mrsf_top mrsf_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_mon (.clk, .rst, .baud_sel, .station_addr,
	.comm_timeout_setting, .rx_valid, .rx_discard, .req_valid, .tx_valid, .tx_data, .tx_ready, .tx_empty,
	.driver_en, .comm_timeout);
`default_nettype wire
